// *** energy_params.svh ***
// constants of the energy combination block: offsets, layouts, resets
// assumes a 32-bit APB with byte addresses and one word per register
`ifndef ENERGY_PARAMS_SVH
`define ENERGY_PARAMS_SVH
`define SRC_W 29
`define TOTAL_W 32
`define SRC_COUNT 4
`define ADDR_ACT_WORD 8'h00
`define ADDR_REACT_WORD1 8'h04
`define ADDR_REACT_WORD2 8'h08
`define ADDR_ACT_TOTAL 8'h0C
`define ADDR_REACT_TOTAL1 8'h10
`define ADDR_REACT_TOTAL2 8'h14
`define ACT_WORD_MASK 8'h0F
`define RST_ACT_WORD 8'h01
`define RST_REACT_WORD1 8'h41
`define RST_REACT_WORD2 8'h14
`endif

// *** energy_pkg.sv ***
// types and the combination arithmetic shared by the block's modules
// assumes energy_params.svh is on the include path
`include "energy_params.svh"
package energy_pkg;
	typedef logic [`SRC_W-1:0] src_t;
	typedef logic signed [`TOTAL_W-1:0] total_t;
	typedef src_t [`SRC_COUNT-1:0] src_vec_t;
	typedef struct packed {
		logic [7:0] act_word;
		logic [7:0] react_word1;
		logic [7:0] react_word2;
		total_t act_total;
		total_t react_total1;
		total_t react_total2;
		logic [31:0] rdata;
		logic err;
		logic touched;
	} combine_state_t;

	// add and subtract both set cancel to zero
	function automatic total_t contrib(input logic add, input logic sub,
		input src_t v);
		total_t ext;
		ext = signed'({{(`TOTAL_W-`SRC_W){1'b0}}, v});
		if (add && !sub) return ext;
		else if (sub && !add) return -ext;
		else return '0;
	endfunction

	function automatic total_t combine_sum(input logic [7:0] word,
		input src_vec_t src);
		total_t acc;
		acc = '0;
		for (int i = 0; i < `SRC_COUNT; i++) begin
			acc = acc + contrib(word[2*i], word[2*i+1], src[i]);
		end
		return acc;
	endfunction
endpackage

// *** combine_if.sv ***
// carrier between the register block and one combination adder
// assumes the adder is purely combinational
`timescale 1ns/1ps
`default_nettype none
interface combine_if;
	import energy_pkg::*;
	logic [7:0] word;
	src_vec_t src;
	total_t sum;
	modport unit (input word, input src, output sum);
	modport ctrl (output word, output src, input sum);
endinterface
`default_nettype wire

// *** energy_combine_unit.sv ***
// one combination adder: signed sum of up to four sources under a word
// assumes the caller registers the sum
`timescale 1ns/1ps
`default_nettype none
module energy_combine_unit (
	combine_if.unit bus
);
	import energy_pkg::*;
	always_comb begin
		bus.sum = combine_sum(bus.word, bus.src);
	end
endmodule
`default_nettype wire

// *** energy_combination_logic.sv ***
// combined active and reactive energy totals with an APB register file
// assumes front-end accumulators synchronous to pclk, zero-wait APB master
`timescale 1ns/1ps
`default_nettype none
module energy_combination_logic (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire energy_pkg::src_t pos_active_energy,
	input wire energy_pkg::src_t rev_active_energy,
	input wire energy_pkg::src_t quad1_energy,
	input wire energy_pkg::src_t quad2_energy,
	input wire energy_pkg::src_t quad3_energy,
	input wire energy_pkg::src_t quad4_energy,
	output energy_pkg::total_t act_total,
	output energy_pkg::total_t react_total1,
	output energy_pkg::total_t react_total2
);
	import energy_pkg::*;

	combine_state_t s;
	combine_state_t next_s;
	logic setup;
	logic wr_access;
	logic [7:0] off;
	logic upper_ok;
	src_vec_t act_src;
	src_vec_t quad_src;

	combine_if act_bus ();
	combine_if r1_bus ();
	combine_if r2_bus ();

	assign setup = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign off = paddr[7:0];
	assign upper_ok = (paddr[31:8] == 24'h000000);

	// reverse in slot 1, positive in slot 0; upper slots never counted
	assign act_src = '{'0, '0, rev_active_energy, pos_active_energy};
	// each quadrant keeps its own slot so any subset may be combined
	assign quad_src = '{quad4_energy, quad3_energy, quad2_energy,
		quad1_energy};

	assign act_bus.word = s.act_word & `ACT_WORD_MASK;
	assign act_bus.src = act_src;
	assign r1_bus.word = s.react_word1;
	assign r1_bus.src = quad_src;
	assign r2_bus.word = s.react_word2;
	assign r2_bus.src = quad_src;

	energy_combine_unit act_unit (.bus(act_bus.unit));
	energy_combine_unit r1_unit (.bus(r1_bus.unit));
	energy_combine_unit r2_unit (.bus(r2_bus.unit));

	always_comb begin
		next_s = s;
		// totals follow sources and words one cycle later
		next_s.act_total = act_bus.sum;
		next_s.react_total1 = r1_bus.sum;
		next_s.react_total2 = r2_bus.sum;
		// read data and error are settled in setup so the access
		// phase answers from flops without a wait state
		if (setup) begin
			next_s.err = 1'b0;
			next_s.rdata = 32'h00000000;
			if (!upper_ok) begin
				next_s.err = 1'b1;
			end else if (off == `ADDR_ACT_WORD) begin
				next_s.rdata = {24'h000000, s.act_word};
			end else if (off == `ADDR_REACT_WORD1) begin
				next_s.rdata = {24'h000000, s.react_word1};
			end else if (off == `ADDR_REACT_WORD2) begin
				next_s.rdata = {24'h000000, s.react_word2};
			end else if (off == `ADDR_ACT_TOTAL) begin
				next_s.rdata = s.act_total;
				next_s.err = pwrite;
			end else if (off == `ADDR_REACT_TOTAL1) begin
				next_s.rdata = s.react_total1;
				next_s.err = pwrite;
			end else if (off == `ADDR_REACT_TOTAL2) begin
				next_s.rdata = s.react_total2;
				next_s.err = pwrite;
			end else begin
				next_s.err = 1'b1;
			end
		end
		// only byte lane 0 carries a word; other lanes are ignored
		if (wr_access && !s.err && pstrb[0]) begin
			if (off == `ADDR_ACT_WORD) begin
				next_s.act_word = pwdata[7:0];
				next_s.touched = 1'b1;
			end else if (off == `ADDR_REACT_WORD1) begin
				next_s.react_word1 = pwdata[7:0];
				next_s.touched = 1'b1;
			end else if (off == `ADDR_REACT_WORD2) begin
				next_s.react_word2 = pwdata[7:0];
				next_s.touched = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.act_word <= `RST_ACT_WORD;
			s.react_word1 <= `RST_REACT_WORD1;
			s.react_word2 <= `RST_REACT_WORD2;
		end else begin
			s <= next_s;
		end
	end

	assign pready = psel && penable;
	assign pslverr = psel && penable && s.err;
	assign prdata = s.rdata;
	assign act_total = s.act_total;
	assign react_total1 = s.react_total1;
	assign react_total2 = s.react_total2;

	// checks
	total_t pos_ext;
	total_t rev_ext;
	total_t q_ext [4];
	assign pos_ext = signed'({3'h0, pos_active_energy});
	assign rev_ext = signed'({3'h0, rev_active_energy});
	assign q_ext[0] = signed'({3'h0, quad1_energy});
	assign q_ext[1] = signed'({3'h0, quad2_energy});
	assign q_ext[2] = signed'({3'h0, quad3_energy});
	assign q_ext[3] = signed'({3'h0, quad4_energy});

	AST_ACT_BITS: assert property (@(posedge pclk) disable iff (!presetn)
		act_total == $past(combine_sum({4'h0, s.act_word[3:0]}, act_src)))
	else $error("active total does not follow its word");

	AST_ACT_05: assert property (@(posedge pclk) disable iff (!presetn)
		(s.act_word == 8'h05) |=> (act_total == $past(pos_ext + rev_ext)))
	else $error("word 05 is not positive plus reverse");

	AST_ACT_DEFAULT: assert property (@(posedge pclk)
		disable iff (!presetn)
		(!s.touched && $past(presetn)) |=> (act_total == $past(pos_ext)))
	else $error("default active total is not positive alone");

	AST_QUAD_SEP: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s.react_word1 == 8'h10) |=> (react_total1 == $past(q_ext[2])))
	else $error("quadrant III not isolated");

	AST_REACT_PAIRS: assert property (@(posedge pclk)
		disable iff (!presetn)
		react_total2 == $past(combine_sum(s.react_word2, quad_src)))
	else $error("reactive total 2 does not follow its word");

	AST_SUB_ONLY: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s.react_word1 == 8'h02) |=> (react_total1 == -$past(q_ext[0])))
	else $error("subtract bit does not deduct quadrant I");

	AST_REACT_A5: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s.react_word1 == 8'hA5) |=> (react_total1 ==
		$past(q_ext[0] + q_ext[1] - q_ext[2] - q_ext[3])))
	else $error("word A5 is not I+II-III-IV");

	AST_REACT_DEFAULT: assert property (@(posedge pclk)
		disable iff (!presetn)
		(!s.touched && $past(presetn)) |=>
		(react_total1 == $past(q_ext[0] + q_ext[3])) &&
		(react_total2 == $past(q_ext[1] + q_ext[2])))
	else $error("default reactive totals wrong");

	AST_CANCEL: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s.react_word2 == 8'hFF) |=> (react_total2 == 32'sh00000000))
	else $error("add and subtract together do not cancel");

	AST_WORD_WRITE: assert property (@(posedge pclk)
		disable iff (!presetn)
		(wr_access && !s.err && pstrb[0] && off == `ADDR_ACT_WORD
		&& upper_ok) |=> (s.act_word == $past(pwdata[7:0]))
		##1 (act_total == $past(combine_sum({4'h0, s.act_word[3:0]},
		act_src))))
	else $error("active word write not applied");

	AST_TOTAL_RO: assert property (@(posedge pclk)
		disable iff (!presetn)
		(setup && pwrite && upper_ok && off == `ADDR_ACT_TOTAL)
		|=> pslverr)
	else $error("write to a total is not refused");

	COV_ACT_05: cover property (@(posedge pclk) disable iff (!presetn)
		s.act_word == 8'h05 ##1 act_total != 32'sh00000000);
	COV_REACT_A5: cover property (@(posedge pclk) disable iff (!presetn)
		s.react_word1 == 8'hA5 ##1 react_total1 < 32'sh00000000);
	COV_BAD_ADDR: cover property (@(posedge pclk) disable iff (!presetn)
		pslverr && !pwrite);
	COV_READ_TOTAL: cover property (@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && off == `ADDR_REACT_TOTAL2);
endmodule
`default_nettype wire

// *** energy_source_model.sv ***
// far-side model: the front-end accumulators feeding the combination block
// assumes the bench loads new readings between clock edges by strobe
`timescale 1ns/1ps
`default_nettype none
module energy_source_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire energy_pkg::src_t next_pos,
	input wire energy_pkg::src_t next_rev,
	input wire energy_pkg::src_vec_t next_quad,
	output energy_pkg::src_t pos,
	output energy_pkg::src_t rev,
	output energy_pkg::src_vec_t quad
);
	import energy_pkg::*;
	// each quadrant kept in its own accumulator, never merged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos <= '0;
			rev <= '0;
			quad <= '0;
		end else if (load) begin
			pos <= next_pos;
			rev <= next_rev;
			quad <= next_quad;
		end
	end
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench: APB register traffic plus combination table
// assumes zero-wait APB slave and one-cycle total latency per hand-over
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
	n_errors++; $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module testbench;
	import energy_pkg::*;
	typedef struct {logic [31:0] a; logic [7:0] w; logic [31:0] e;} row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, load = 0;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, er;
	src_t pos, rev, n_pos = 29'h64, n_rev = 29'h1E;
	src_vec_t quad, n_quad;
	total_t act_total, react_total1, react_total2;
	int n_errors = 0, num_checks = 0;
	row_t rows[16] = '{
		'{32'h0, 8'h05, 32'h82}, '{32'h0, 8'h01, 32'h64},
		'{32'h0, 8'h02, 32'hFFFFFF9C}, '{32'h0, 8'h06, 32'hFFFFFFBA},
		'{32'h0, 8'h0A, 32'hFFFFFF7E}, '{32'h0, 8'h03, 32'h0},
		'{32'h4, 8'hA5, 32'h48E}, '{32'h4, 8'h55, 32'h4D2},
		'{32'h4, 8'hAA, 32'hFFFFFB2E}, '{32'h4, 8'h99, 32'h33A},
		'{32'h4, 8'h10, 32'h1E}, '{32'h4, 8'h02, 32'hFFFFFC18},
		'{32'h4, 8'h0F, 32'h0}, '{32'h8, 8'hFF, 32'h0},
		'{32'h8, 8'hA5, 32'h48E},
		'{32'h0, 8'hF5, 32'h82}};
	always #4 pclk = ~pclk;
	energy_source_model src_u (.pclk(pclk), .presetn(presetn), .load(load),
		.next_pos(n_pos), .next_rev(n_rev), .next_quad(n_quad), .pos(pos),
		.rev(rev), .quad(quad));
	energy_combination_logic dut_u (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pos_active_energy(pos), .rev_active_energy(rev),
		.quad1_energy(quad[0]), .quad2_energy(quad[1]),
		.quad3_energy(quad[2]), .quad4_energy(quad[3]),
		.act_total(act_total), .react_total1(react_total1),
		.react_total2(react_total2));
	task automatic conclude();
		if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (k >= 50) begin
			n_errors++;
			conclude();
		end
		// one idle edge so a following call never reassigns psel at once
		@(posedge pclk);
	endtask
	task automatic settle();
		repeat (2) @(posedge pclk);
		#1;
	endtask
	initial begin
		n_quad = {29'h4, 29'h1E, 29'hC8, 29'h3E8};
		repeat (19) @(posedge pclk);
		#1;
		`CHK("act_total in reset", 32'h0, act_total)
		@(posedge pclk);
		presetn <= 1;
		load <= 1;
		settle();
		`CHK("reset act_total", 32'h64, act_total)
		`CHK("reset react_total1", 32'h3EC, react_total1)
		`CHK("reset react_total2", 32'hE6, react_total2)
		@(posedge pclk);
		apb(0, 32'h0, 0);
		`CHK("act word", 32'h01, rd)
		apb(0, 32'h4, 0);
		`CHK("react word1", 32'h41, rd)
		apb(0, 32'h8, 0);
		`CHK("react word2", 32'h14, rd)
		foreach (rows[i]) begin
			apb(1, rows[i].a, {24'h0, rows[i].w});
			settle();
			`CHK("total", rows[i].e, rows[i].a == 0 ? act_total :
				rows[i].a == 4 ? react_total1 : react_total2)
		end
		`CHK("active A5 F5", 32'h82, act_total)
		`CHK("word2 A5", 32'h48E, react_total2)
		apb(0, 32'h0C, 0);
		`CHK("act total read", 32'h82, rd)
		apb(0, 32'h18, 0);
		`CHK("unmapped err", 1'b1, er)
		apb(1, 32'h0C, 32'h1);
		`CHK("read-only err", 1'b1, er)
		// strobe off: write must be dropped silently
		pstrb <= 4'h0;
		apb(1, 32'h4, 32'h2);
		pstrb <= 4'hF;
		`CHK("no strobe err", 1'b0, er)
		apb(0, 32'h4, 0);
		`CHK("word1 kept", 32'h0F, rd)
		apb(1, 32'h4, 32'h80);
		settle();
		`CHK("sub only IV", 32'hFFFFFFFC, react_total1)
		n_pos <= 29'h1FFFFFFF;
		settle();
		`CHK("source change", 32'h2000001D, act_total)
		conclude();
	end
endmodule
`default_nettype wire
